// ==== logic/dmac_pkg.sv ====
package dmac_pkg;

  // datapath widths
  localparam int OP_W  = 16;
  localparam int MUL_W = 17;
  localparam int ACC_W = 40;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TRAP   = 8'h04;
  localparam logic [7:0] OFS_OPA    = 8'h08;
  localparam logic [7:0] OFS_OPB    = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  localparam logic [7:0] OFS_ACCUMULATOR_A_L = 8'h18;
  localparam logic [7:0] OFS_ACCUMULATOR_A_H = 8'h1C;
  localparam logic [7:0] OFS_ACCUMULATOR_B_L = 8'h20;
  localparam logic [7:0] OFS_ACCUMULATOR_B_H = 8'h24;
  localparam logic [7:0] OFS_PROD   = 8'h28;

  // core control fields
  localparam int CTL_CLAMP_A = 7;
  localparam int CTL_CLAMP_B = 6;
  localparam int CTL_WIDE    = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // trap control fields
  localparam int TRP_EN_A = 0;
  localparam int TRP_EN_B = 1;
  // status fields
  localparam int ST_GUARD_A = 0;
  localparam int ST_GUARD_B = 1;
  localparam int ST_CLAMP_A = 2;
  localparam int ST_CLAMP_B = 3;
  localparam int ST_CATAS_A = 4;
  localparam int ST_CATAS_B = 5;
  localparam int ST_EGUARD  = 6;
  localparam int ST_ECLAMP  = 7;

  // clamp targets
  localparam logic [39:0] SAT_POS_NARROW = 40'h00_7FFF_FFFF;
  localparam logic [39:0] SAT_NEG_NARROW = 40'hFF_8000_0000;
  localparam logic [39:0] SAT_POS_WIDE   = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT_NEG_WIDE   = 40'h80_0000_0000;

  // operations of the command register
  typedef enum logic [2:0] {
    OPC_PRODUCT = 3'h0,
    OPC_MAC     = 3'h1,
    OPC_MSC     = 3'h2,
    OPC_ADD     = 3'h3,
    OPC_LOAD    = 3'h4,
    OPC_CLEAR   = 3'h5
  } dmac_opc_type;

  // command word, bits 11:0 of a write to the command register
  typedef struct packed {
    logic signed [3:0] shift;     // 11:8 positive shifts right
    logic              byte_op;   // 7
    logic              frac;      // 6
    logic              b_signed;  // 5
    logic              a_signed;  // 4
    logic              acc_sel;   // 3 zero selects accumulator a
    dmac_opc_type      opc;       // 2:0
  } dmac_cmd_type;

endpackage : dmac_pkg

// ==== logic/dmac_datapath.sv ====
// What this block does
// - 17x17 multiplier, signed or unsigned, scaled to 1.31 fraction or 32-bit integer
// - unsigned operand gets zero in its seventeenth multiplier bit
// - signed operand gets its sign copied into the seventeenth bit
// - integer operands are two's complement, 0x8000 most negative, 0x7FFF most positive
// - fractional mode: radix after sign, 16x16 gives a 1.31 product
// - same multiplier serves signed, unsigned and mixed integer multiplies
// - byte operands give a 16-bit result, word operands a 32-bit result
// - 40-bit adder/subtracter with sign extension, accumulator a or b as source/destination
// - add and load-accumulator data may pass a barrel shifter first
// - adder takes optional zero on one input, true or inverted operand on other
// - add uses carry active high; subtract inverts operand, carry is active-low borrow
// - overflow out of bit 39 is flagged as catastrophic, sign destroyed
// - guard flag set when accumulator bits 32 to 39 differ
// - clamping uses result, overflow, per-accumulator enables 7:6 and wide select 4
// - clamped flag set on bit 31 overflow or guard overflow clamped at bit 39
// - combined bits: OR of both guard flags, OR of both clamped flags
// - guard flags follow each operation, reflecting only the latest one
// - clamped and catastrophic flags are latched and stay visible
// - warning trap when a guard flag and its trap enable are both set
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
module dmac_datapath
  import dmac_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // trap to the exception logic
  output logic             ARITH_TRAP
);

  logic [7:0]          core_control_reg_ff;
  logic [1:0]          trap_control_reg_ff;
  logic [OP_W-1:0]     opa_ff;
  logic [OP_W-1:0]     opb_ff;
  logic [ACC_W-1:0]    accumulator_a_ff;
  logic [ACC_W-1:0]    accumulator_b_ff;
  logic [31:0]         prod_ff;
  logic                acc_a_guard_flag_ff;
  logic                acc_b_guard_flag_ff;
  logic                acc_a_clamped_flag_ff;
  logic                acc_b_clamped_flag_ff;
  logic                acc_a_catas_ff;
  logic                acc_b_catas_ff;
  logic                ack_ff;
  logic                trap_ff;
  logic [31:0]         dat_ff;

  // request decode; a write acts in the cycle before ack
  logic req;
  logic wr_en;
  logic exec;
  dmac_cmd_type cmd;
  assign req   = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wr_en = req & WB_WE_I;
  assign exec  = wr_en & (WB_ADR_I == OFS_CMD) & WB_SEL_I[0] & WB_SEL_I[1];
  assign cmd   = dmac_cmd_type'(WB_DAT_I[11:0]);

  // operand conditioning: byte ops narrow to 8 bits first, then extend to 17
  logic [OP_W-1:0]  a16;
  logic [OP_W-1:0]  b16;
  logic [MUL_W-1:0] a17;
  logic [MUL_W-1:0] b17;
  always_comb
  begin
    if (cmd.byte_op)
    begin
      a16 = {{8{cmd.a_signed & opa_ff[7]}}, opa_ff[7:0]};
      b16 = {{8{cmd.b_signed & opb_ff[7]}}, opb_ff[7:0]};
    end
    else
    begin
      a16 = opa_ff;
      b16 = opb_ff;
    end
  end
  assign a17 = {cmd.a_signed & a16[OP_W-1], a16};
  assign b17 = {cmd.b_signed & b16[OP_W-1], b16};

  // 17x17 signed multiply; the 34-bit product never uses its top two bits
  logic signed [2*MUL_W-1:0] prod_full;
  logic [31:0]               prod_scaled;
  assign prod_full = $signed(a17) * $signed(b17);
  always_comb
  begin
    if (cmd.byte_op)
      prod_scaled = {16'h0000, prod_full[15:0]};
    else if (cmd.frac)
      prod_scaled = {prod_full[30:0], 1'b0};
    else
      prod_scaled = prod_full[31:0];
  end

  // barrel shifter: 16-bit data sits at bits 31:16 of the 40-bit word
  logic signed [ACC_W-1:0] shin;
  logic [ACC_W-1:0]        shifted;
  logic [3:0]              shmag;
  assign shin  = $signed({{8{opa_ff[OP_W-1]}}, opa_ff, 16'h0000});
  assign shmag = cmd.shift[3] ? 4'(-cmd.shift) : 4'(cmd.shift);
  assign shifted = cmd.shift[3] ? ACC_W'(shin <<< shmag) : ACC_W'(shin >>> shmag);

  // adder inputs: x may be forced to zero, y true or inverted
  logic [ACC_W-1:0] acc_src;
  logic [ACC_W-1:0] x_in;
  logic [ACC_W-1:0] y_data;
  logic [ACC_W-1:0] y_in;
  logic             sub;
  logic             cin;
  logic [ACC_W:0]   sum;
  assign acc_src = cmd.acc_sel ? accumulator_b_ff : accumulator_a_ff;
  assign sub     = (cmd.opc == OPC_MSC);
  assign x_in    = (cmd.opc == OPC_LOAD || cmd.opc == OPC_CLEAR) ? '0 : acc_src;
  always_comb
  begin
    case (cmd.opc)
      OPC_MAC, OPC_MSC: y_data = {{8{prod_scaled[31]}}, prod_scaled};
      OPC_ADD, OPC_LOAD: y_data = shifted;
      default: y_data = '0;
    endcase
  end
  assign y_in = sub ? ~y_data : y_data;
  assign cin  = sub;
  assign sum  = {1'b0, x_in} + {1'b0, y_in} + {{ACC_W{1'b0}}, cin};

  // overflow detection on the raw sum
  logic ovf39;
  logic ovf31;
  logic true_neg;
  assign ovf39    = (x_in[39] == y_in[39]) & (sum[39] != x_in[39]);
  assign ovf31    = ~((&sum[39:31]) | ~(|sum[39:31]));
  assign true_neg = ovf39 ? ~sum[39] : sum[39];

  // saturation: narrow clamps at bit 31, wide clamps only on bit 39 overflow
  logic             clamp_en;
  logic             wide;
  logic             do_clamp;
  logic [ACC_W-1:0] result;
  assign clamp_en = cmd.acc_sel ? core_control_reg_ff[CTL_CLAMP_B]
                                : core_control_reg_ff[CTL_CLAMP_A];
  assign wide     = core_control_reg_ff[CTL_WIDE];
  assign do_clamp = clamp_en & (wide ? ovf39 : (ovf31 | ovf39));
  always_comb
  begin
    if (!do_clamp)
      result = sum[ACC_W-1:0];
    else if (wide)
      result = true_neg ? SAT_NEG_WIDE : SAT_POS_WIDE;
    else
      result = true_neg ? SAT_NEG_NARROW : SAT_POS_NARROW;
  end

  logic guard_res;
  logic upd_acc;
  assign guard_res = ~((&result[39:32]) | ~(|result[39:32]));
  assign upd_acc   = exec & (cmd.opc != OPC_PRODUCT) & (cmd.opc <= OPC_CLEAR);

  // control and operand registers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      core_control_reg_ff <= CTRL_RST;
      trap_control_reg_ff <= 2'h0;
      opa_ff              <= 16'h0000;
      opb_ff              <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (WB_ADR_I == OFS_CTRL && WB_SEL_I[0])
        core_control_reg_ff <= WB_DAT_I[7:0];
      if (WB_ADR_I == OFS_TRAP && WB_SEL_I[0])
        trap_control_reg_ff <= WB_DAT_I[1:0];
      if (WB_ADR_I == OFS_OPA && WB_SEL_I[0])
        opa_ff[7:0] <= WB_DAT_I[7:0];
      if (WB_ADR_I == OFS_OPA && WB_SEL_I[1])
        opa_ff[15:8] <= WB_DAT_I[15:8];
      if (WB_ADR_I == OFS_OPB && WB_SEL_I[0])
        opb_ff[7:0] <= WB_DAT_I[7:0];
      if (WB_ADR_I == OFS_OPB && WB_SEL_I[1])
        opb_ff[15:8] <= WB_DAT_I[15:8];
    end
  end

  // accumulators and product; direct low-word accumulator writes need all four byte selects, high-byte writes only byte 0
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      accumulator_a_ff <= '0;
      accumulator_b_ff <= '0;
      prod_ff          <= 32'h0000_0000;
    end
    else
    begin
      if (exec && cmd.opc == OPC_PRODUCT)
        prod_ff <= prod_scaled;
      if (upd_acc && !cmd.acc_sel)
        accumulator_a_ff <= result;
      else if (wr_en && WB_ADR_I == OFS_ACCUMULATOR_A_L && WB_SEL_I == 4'hF)
        accumulator_a_ff[31:0] <= WB_DAT_I;
      else if (wr_en && WB_ADR_I == OFS_ACCUMULATOR_A_H && WB_SEL_I[0])
        accumulator_a_ff[39:32] <= WB_DAT_I[7:0];
      if (upd_acc && cmd.acc_sel)
        accumulator_b_ff <= result;
      else if (wr_en && WB_ADR_I == OFS_ACCUMULATOR_B_L && WB_SEL_I == 4'hF)
        accumulator_b_ff[31:0] <= WB_DAT_I;
      else if (wr_en && WB_ADR_I == OFS_ACCUMULATOR_B_H && WB_SEL_I[0])
        accumulator_b_ff[39:32] <= WB_DAT_I[7:0];
    end
  end

  // guard flags are not sticky: each operation on an accumulator rewrites its flag
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      acc_a_guard_flag_ff <= 1'b0;
      acc_b_guard_flag_ff <= 1'b0;
    end
    else if (upd_acc)
    begin
      if (!cmd.acc_sel)
        acc_a_guard_flag_ff <= guard_res;
      else
        acc_b_guard_flag_ff <= guard_res;
    end
  end

  // sticky flags: write one to clear, a new event in the same cycle wins
  logic clr_stat;
  logic [5:0] clr_bits;
  assign clr_stat = wr_en & (WB_ADR_I == OFS_STAT) & WB_SEL_I[0];
  assign clr_bits = clr_stat ? WB_DAT_I[5:0] : 6'h00;
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      acc_a_clamped_flag_ff <= 1'b0;
      acc_b_clamped_flag_ff <= 1'b0;
      acc_a_catas_ff        <= 1'b0;
      acc_b_catas_ff        <= 1'b0;
    end
    else
    begin
      acc_a_clamped_flag_ff <= (upd_acc & ~cmd.acc_sel & do_clamp)
        | (acc_a_clamped_flag_ff & ~clr_bits[ST_CLAMP_A]);
      acc_b_clamped_flag_ff <= (upd_acc & cmd.acc_sel & do_clamp)
        | (acc_b_clamped_flag_ff & ~clr_bits[ST_CLAMP_B]);
      acc_a_catas_ff <= (upd_acc & ~cmd.acc_sel & ovf39)
        | (acc_a_catas_ff & ~clr_bits[ST_CATAS_A]);
      acc_b_catas_ff <= (upd_acc & cmd.acc_sel & ovf39)
        | (acc_b_catas_ff & ~clr_bits[ST_CATAS_B]);
    end
  end

  // trap follows the guard flags one cycle later, held while they stay set
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      trap_ff <= 1'b0;
    else
      trap_ff <= (acc_a_guard_flag_ff & trap_control_reg_ff[TRP_EN_A])
               | (acc_b_guard_flag_ff & trap_control_reg_ff[TRP_EN_B]);
  end
  assign ARITH_TRAP = trap_ff;

  // status word with the combined bits
  logic [31:0] stat_word;
  always_comb
  begin
    stat_word              = 32'h0000_0000;
    stat_word[ST_GUARD_A]  = acc_a_guard_flag_ff;
    stat_word[ST_GUARD_B]  = acc_b_guard_flag_ff;
    stat_word[ST_CLAMP_A]  = acc_a_clamped_flag_ff;
    stat_word[ST_CLAMP_B]  = acc_b_clamped_flag_ff;
    stat_word[ST_CATAS_A]  = acc_a_catas_ff;
    stat_word[ST_CATAS_B]  = acc_b_catas_ff;
    stat_word[ST_EGUARD]   = acc_a_guard_flag_ff | acc_b_guard_flag_ff;
    stat_word[ST_ECLAMP]   = acc_a_clamped_flag_ff | acc_b_clamped_flag_ff;
  end

  // read mux; unmapped offsets read zero and still ack
  logic [31:0] rd_mux;
  always_comb
  begin
    case (WB_ADR_I)
      OFS_CTRL:   rd_mux = {24'h000000, core_control_reg_ff};
      OFS_TRAP:   rd_mux = {30'h0, trap_control_reg_ff};
      OFS_OPA:    rd_mux = {16'h0000, opa_ff};
      OFS_OPB:    rd_mux = {16'h0000, opb_ff};
      OFS_STAT:   rd_mux = stat_word;
      OFS_ACCUMULATOR_A_L: rd_mux = accumulator_a_ff[31:0];
      OFS_ACCUMULATOR_A_H: rd_mux = {24'h000000, accumulator_a_ff[39:32]};
      OFS_ACCUMULATOR_B_L: rd_mux = accumulator_b_ff[31:0];
      OFS_ACCUMULATOR_B_H: rd_mux = {24'h000000, accumulator_b_ff[39:32]};
      OFS_PROD:   rd_mux = prod_ff;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: ack and data register together, ack drops the next cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req;
      if (req && !WB_WE_I)
        dat_ff <= rd_mux;
    end
  end
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // checks share the system clock and reset; reference product is word mode only
  logic signed [33:0] ref_prod;
  assign ref_prod = $signed({opa_ff[15] & cmd.a_signed, opa_ff})
                  * $signed({opb_ff[15] & cmd.b_signed, opb_ff});

  zero_ext_a: assert property (exec && !cmd.a_signed |-> a17[16] == 1'b0)
    else $error("unsigned operand not zero extended");
  sign_ext_a: assert property (exec && cmd.a_signed |-> a17[16] == a16[15])
    else $error("signed operand not sign extended");
  int_prod_a: assert property (exec && cmd.opc == OPC_PRODUCT && !cmd.frac && !cmd.byte_op
    |=> prod_ff == $past(ref_prod[31:0]))
    else $error("integer product wrong");
  frac_prod_a: assert property (exec && cmd.opc == OPC_PRODUCT && cmd.frac && !cmd.byte_op
    |=> prod_ff == {$past(ref_prod[30:0]), 1'b0})
    else $error("fractional product not 1.31");
  guard_flag_a: assert property (upd_acc && !cmd.acc_sel
    |=> acc_a_guard_flag_ff == !((&accumulator_a_ff[39:32]) || !(|accumulator_a_ff[39:32])))
    else $error("guard flag disagrees with accumulator a");
  narrow_clamp_a: assert property (upd_acc && !cmd.acc_sel && clamp_en && !wide
    |=> (&accumulator_a_ff[39:31]) || !(|accumulator_a_ff[39:31]))
    else $error("narrow clamp left accumulator a out of range");
  sticky_clamp_a: assert property (acc_a_clamped_flag_ff && !clr_bits[ST_CLAMP_A]
    |=> acc_a_clamped_flag_ff)
    else $error("clamped flag a lost");
  trap_raise_a: assert property (acc_b_guard_flag_ff && trap_control_reg_ff[TRP_EN_B]
    |=> ARITH_TRAP)
    else $error("trap not raised for accumulator b");
  // a trap with no guard flag behind it would stall software for nothing
  trap_drop_a: assert property (!acc_a_guard_flag_ff && !acc_b_guard_flag_ff
    |=> !ARITH_TRAP)
    else $error("trap raised without a guard flag");
  catas_flag_a: assert property (upd_acc && cmd.acc_sel && ovf39 |=> acc_b_catas_ff)
    else $error("bit 39 overflow not latched");
  wb_ack_a: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single cycle after request");

  mac_clamp_c: cover property (upd_acc && cmd.opc == OPC_MAC && do_clamp);
  sub_op_c: cover property (upd_acc && cmd.opc == OPC_MSC);
  trap_c: cover property (!ARITH_TRAP ##1 ARITH_TRAP);
  byte_prod_c: cover property (exec && cmd.opc == OPC_PRODUCT && cmd.byte_op);
  wide_clamp_c: cover property (upd_acc && wide && do_clamp);

endmodule : dmac_datapath

// ==== verification/dmac_core_model.sv ====
module dmac_core_model
(
  // bus clock
  input  wire logic        clk,
  // master request
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dout,
  // slave answer
  input  wire logic [31:0] din,
  input  wire logic        ack
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus from time zero
  initial
  begin
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    sel  = 4'h0;
    dout = 32'h0000_0000;
  end

  // one classic cycle, request held until the edge that samples ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    dout <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = din;
    // released data carries the inverse so a stale word never looks valid
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
    dout <= ~d;
  endtask : xfer
endmodule : dmac_core_model

// ==== verification/tb.sv ====
module tb
  import dmac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        trap;
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  logic [7:0]  rst_adr [8] = '{OFS_CTRL, OFS_TRAP, OFS_CMD, OFS_STAT,
                               OFS_ACCUMULATOR_A_L, OFS_ACCUMULATOR_B_H, OFS_PROD, 8'h30};

  // 20 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  dmac_datapath dut (
    .CLK_SYS    (clk),
    .RST_N      (rst_n),
    .WB_CYC_I   (cyc),
    .WB_STB_I   (stb),
    .WB_WE_I    (we),
    .WB_ADR_I   (adr),
    .WB_SEL_I   (sel),
    .WB_DAT_I   (wdat),
    .WB_DAT_O   (rdat),
    .WB_ACK_O   (ack),
    .ARITH_TRAP (trap)
  );

  dmac_core_model u_core (
    .clk  (clk),
    .cyc  (cyc),
    .stb  (stb),
    .we   (we),
    .adr  (adr),
    .sel  (sel),
    .dout (wdat),
    .din  (rdat),
    .ack  (ack)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    u_core.xfer(1'b1, a, s, d, q);
  endtask : wr

  task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_core.xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask : rdck

  // accumulator is high byte over low word
  task automatic accck(input logic b, input logic [39:0] exp);
    logic [31:0] h;
    logic [31:0] l;
    u_core.xfer(1'b0, b ? OFS_ACCUMULATOR_B_H : OFS_ACCUMULATOR_A_H, 4'hF, 32'h0000_0000, h);
    u_core.xfer(1'b0, b ? OFS_ACCUMULATOR_B_L : OFS_ACCUMULATOR_A_L, 4'hF, 32'h0000_0000, l);
    chk({h[7:0], l}, exp);
  endtask : accck

  // flags: byte, frac, b signed, a signed
  task automatic op(input dmac_opc_type o, input logic b, input logic [3:0] fl,
                    input logic [3:0] sh);
    dmac_cmd_type c;
    c = {sh, fl, b, o};
    wr(OFS_CMD, 4'h3, {20'h00000, c});
  endtask : op

  task automatic prod(input logic [15:0] a, input logic [15:0] b, input logic [3:0] fl,
                      input logic [31:0] exp);
    wr(OFS_OPA, 4'hF, {16'h0000, a});
    wr(OFS_OPB, 4'hF, {16'h0000, b});
    op(OPC_PRODUCT, 1'b0, fl, 4'h0);
    rdck(OFS_PROD, exp);
  endtask : prod

  // trap is registered one cycle behind flags and enables
  task automatic tchk(input logic e);
    @(posedge clk);
    chk({39'h0, trap}, {39'h0, e});
  endtask : tchk

  // watchdog well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset state, command and unmapped places read zero
    foreach (rst_adr[i]) rdck(rst_adr[i], 32'h0000_0000);
    tchk(1'b0);
    // multiplier sign fill, scaler and operand width
    prod(16'h8000, 16'h8000, 4'h3, 32'h4000_0000);
    prod(16'hFFFF, 16'hFFFF, 4'h0, 32'hFFFE_0001);
    prod(16'hFFFF, 16'h0002, 4'h1, 32'hFFFF_FFFE);
    prod(16'h4000, 16'h4000, 4'h7, 32'h2000_0000);
    prod(16'h12FF, 16'h34FF, 4'h8, 32'h0000_FE01);
    prod(16'h12FF, 16'h3402, 4'hB, 32'h0000_FFFE);
    // four accumulations spill into the guard byte of a
    prod(16'h8000, 16'h8000, 4'h3, 32'h4000_0000);
    op(OPC_CLEAR, 1'b0, 4'h3, 4'h0);
    repeat (4) op(OPC_MAC, 1'b0, 4'h3, 4'h0);
    accck(1'b0, 40'h01_0000_0000);
    rdck(OFS_STAT, 32'h0000_0041);
    wr(OFS_TRAP, 4'hF, 32'h0000_0002);
    tchk(1'b0);
    wr(OFS_TRAP, 4'hF, 32'h0000_0001);
    tchk(1'b1);
    op(OPC_CLEAR, 1'b0, 4'h3, 4'h0);
    rdck(OFS_STAT, 32'h0000_0000);
    tchk(1'b0);
    wr(OFS_TRAP, 4'hF, 32'h0000_0000);
    // subtract into b leaves a alone
    op(OPC_CLEAR, 1'b1, 4'h3, 4'h0);
    op(OPC_MSC, 1'b1, 4'h3, 4'h0);
    accck(1'b1, 40'hFF_C000_0000);
    accck(1'b0, 40'h00_0000_0000);
    // load and add through the shifter
    wr(OFS_OPA, 4'hF, 32'h0000_0001);
    op(OPC_LOAD, 1'b0, 4'h3, 4'h0);
    accck(1'b0, 40'h00_0001_0000);
    op(OPC_LOAD, 1'b0, 4'h3, 4'hC);
    accck(1'b0, 40'h00_0010_0000);
    wr(OFS_OPA, 4'hF, 32'h0000_8000);
    op(OPC_LOAD, 1'b0, 4'h3, 4'h1);
    accck(1'b0, 40'hFF_C000_0000);
    op(OPC_ADD, 1'b0, 4'h3, 4'h1);
    accck(1'b0, 40'hFF_8000_0000);
    // narrow clamp on a only
    wr(OFS_CTRL, 4'h1, 32'h0000_0080);
    wr(OFS_OPA, 4'hF, 32'h0000_7FFF);
    op(OPC_LOAD, 1'b0, 4'h3, 4'h0);
    op(OPC_ADD, 1'b0, 4'h3, 4'h0);
    accck(1'b0, 40'h00_7FFF_FFFF);
    op(OPC_LOAD, 1'b1, 4'h3, 4'h0);
    op(OPC_ADD, 1'b1, 4'h3, 4'h0);
    accck(1'b1, 40'h00_FFFE_0000);
    rdck(OFS_STAT, 32'h0000_0084);
    wr(OFS_OPA, 4'hF, 32'h0000_8000);
    op(OPC_LOAD, 1'b0, 4'h3, 4'h0);
    op(OPC_ADD, 1'b0, 4'h3, 4'h0);
    accck(1'b0, 40'hFF_8000_0000);
    op(OPC_CLEAR, 1'b0, 4'h3, 4'h0);
    rdck(OFS_STAT, 32'h0000_0084);
    wr(OFS_STAT, 4'h1, 32'h0000_0004);
    rdck(OFS_STAT, 32'h0000_0000);
    // sign lost out of bit 39, then the same with wide clamp on b
    wr(OFS_CTRL, 4'h1, 32'h0000_0000);
    wr(OFS_OPA, 4'hF, 32'h0000_7FFF);
    op(OPC_LOAD, 1'b1, 4'h3, 4'h8);
    op(OPC_ADD, 1'b1, 4'h3, 4'h8);
    accck(1'b1, 40'hFF_FE00_0000);
    rdck(OFS_STAT, 32'h0000_0020);
    wr(OFS_STAT, 4'h1, 32'h0000_0020);
    wr(OFS_CTRL, 4'h1, 32'h0000_0050);
    op(OPC_LOAD, 1'b1, 4'h3, 4'h8);
    op(OPC_ADD, 1'b1, 4'h3, 4'h8);
    accck(1'b1, 40'h7F_FFFF_FFFF);
    rdck(OFS_STAT, 32'h0000_00EA);
    // guard flag of b is still set, so enabling its trap raises it
    wr(OFS_TRAP, 4'hF, 32'h0000_0002);
    tchk(1'b1);
    final_report();
  end
endmodule : tb
